// ### ext_bus_cfg.svh
// Constants for the external bus strobe port
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH
`define ADDR_W          32
`define DATA_W          48
`define BANKS           4
`define PAGE_SHIFT_BASE 8
`define BANK_SHIFT_BASE 12
`define DRAM_BANK       2'h0
`define PAGE_SEL_W      3
`define BANK_SEL_W      4
`endif

// ### ext_bus_pkg.sv
// Types for the external bus strobe port
`include "ext_bus_cfg.svh"
package ext_bus_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_STROBE, ST_HALT, ST_FLOAT, ST_GRANT
  } bus_fsm_t;

  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic                 cond;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   wdata;
  } core_req_t;

  typedef struct packed {
    logic                 req;
    logic                 write;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   wdata;
  } slave_req_t;

  typedef struct packed {
    bus_fsm_t             fsm;
    logic                 write;
    logic                 cond;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   wdata;
    logic [`BANKS-1:0]    ms_n;
    logic                 rd_n;
    logic                 wr_n;
    logic                 sw_n;
    logic                 page;
    logic                 ctl_oe_n;
    logic                 data_oe_n;
    logic                 ack_o;
    logic                 ack_oe_n;
    logic                 grant_n;
    logic                 ack_keep;
    logic [`ADDR_W-1:0]   last_row;
    logic                 row_valid;
    logic                 done;
    logic [`DATA_W-1:0]   rdata;
    logic                 strobe_prev;
    slave_req_t           slv;
  } bus_st_t;
endpackage

// ### ext_bus_port.sv
// External bus strobe port: master cycles, slave decode, hand-over
//
// Operation
// R1: Master drives read strobe for external reads
// R2: Outside party drives read strobe to read us
// R3: Master drives write strobe for external writes
// R4: Outside party drives write strobe to write us
// R5: Only bus master drives strobes and select
// R6: Page output flags a crossed DRAM page
// R7: Page output only for bank 0 accesses
// R8: Page size comes from a control field
// R9: Early write select; write may be abandoned
// R10: Write select active with the address
// R11: Slave tells read from write by select
// R12: Host asserts write select on its writes
// R13: Outside parties pull acknowledge low to wait
// R14: Slave drives acknowledge low to add waits
// R15: Slave stretches master access via acknowledge
// R16: Master keeps last driven acknowledge level
// R17: Suspend sampled low floats bus next cycle
// R18: Access under suspend halts until released
// R19: Suspend only for deadlock or DRAM control
// R20: Host asserts request to take the bus
// R21: Master floats bus, then grants the host
// R22: Host request beats multiprocessor requests
// R23: Grant held low until request released
// R24: Bank selects idle unless access, even false
// R25: Access completes only on acknowledge high; a false-condition access here completes after the address cycle without it
`timescale 1ns/10ps
module ext_bus_port
  import ext_bus_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // Core side
  input  wire core_req_t               core_req,
  input  wire logic [`PAGE_SEL_W-1:0]  page_size_sel,
  input  wire logic [`BANK_SEL_W-1:0]  bank_size_sel,
  output logic                         core_done,
  output logic [DATA_W-1:0]            core_rdata,
  // Arbitration
  input  wire logic                    bus_master,
  input  wire logic [5:0]              mp_bus_request_n,
  input  wire logic                    host_bus_request_n,
  output logic                         host_bus_grant_n,
  input  wire logic                    suspend_bus_float_n,
  // Slave side to internal memory
  output slave_req_t                   slave_req,
  input  wire logic                    slave_wait,
  input  wire logic [DATA_W-1:0]       slave_rdata,
  // Address, data, selects
  input  wire logic [ADDR_W-1:0]       addr_in,
  output logic [ADDR_W-1:0]            addr_out,
  output logic                         ctl_oe_n,
  input  wire logic [DATA_W-1:0]       data_in,
  output logic [DATA_W-1:0]            data_out,
  output logic                         data_oe_n,
  output logic [`BANKS-1:0]            memory_bank_select_n,
  output logic                         page_out,
  // Strobes
  input  wire logic                    rd_n_in,
  output logic                         rd_n_out,
  input  wire logic                    wr_n_in,
  output logic                         wr_n_out,
  input  wire logic                    sync_write_select_n_in,
  output logic                         sync_write_select_n_out,
  // Acknowledge
  input  wire logic                    ack_in,
  input  wire logic                    ack_driven,
  output logic                         ack_out,
  output logic                         ack_oe_n
);

  // ----------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------
  function automatic logic [ADDR_W-1:0] page_of(
    input logic [ADDR_W-1:0]      a,
    input logic [`PAGE_SEL_W-1:0] sel);
    page_of = a >> (`PAGE_SHIFT_BASE + sel);
  endfunction

  function automatic logic [1:0] bank_of(
    input logic [ADDR_W-1:0]      a,
    input logic [`BANK_SEL_W-1:0] sel);
    logic [ADDR_W-1:0] s;
    s = a >> (`BANK_SHIFT_BASE + sel);
    bank_of = s[1:0];
  endfunction

  bus_st_t st_ff;
  bus_st_t nxt_st;
  logic    ack_eff;
  logic    host_req;
  logic    susp;
  logic    slv_strobe;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.slv.req = 1'b0;
    // Keeper holds the last driven level when nobody drives
    nxt_st.ack_keep = ack_driven ? ack_in : st_ff.ack_keep; // R16
    ack_eff = ack_driven ? ack_in : st_ff.ack_keep; // R16
    host_req = !host_bus_request_n;
    susp = !suspend_bus_float_n;
    // Host request wins whatever the multiprocessor lines say
    nxt_st.ctl_oe_n = 1'b1;
    nxt_st.data_oe_n = 1'b1;
    unique case (st_ff.fsm)
      ST_IDLE: begin
        nxt_st.ms_n = '1; // R24
        nxt_st.rd_n = 1'b1;
        nxt_st.wr_n = 1'b1;
        nxt_st.sw_n = 1'b1;
        nxt_st.page = 1'b0;
        if (host_req && bus_master) begin
          nxt_st.fsm = ST_FLOAT; // R22
        end else if (bus_master && core_req.valid) begin // R5
          nxt_st.addr = core_req.addr;
          nxt_st.wdata = core_req.wdata;
          nxt_st.write = core_req.write;
          nxt_st.cond = core_req.cond;
          if (susp) begin
            nxt_st.fsm = ST_HALT; // R18
          end else begin
            nxt_st.fsm = ST_ADDR;
            nxt_st.ctl_oe_n = 1'b0;
            nxt_st.ms_n = ~(`BANKS'(1) <<
              bank_of(core_req.addr, bank_size_sel)); // R24
            nxt_st.sw_n = !core_req.write; // R9 R10
            if (bank_of(core_req.addr, bank_size_sel)
                == `DRAM_BANK) begin // R7
              nxt_st.page = !st_ff.row_valid ||
                page_of(core_req.addr, page_size_sel)
                != st_ff.last_row; // R6 R8
              nxt_st.last_row =
                page_of(core_req.addr, page_size_sel); // R8
              nxt_st.row_valid = 1'b1;
            end
          end
        end
      end
      ST_HALT: begin
        if (!susp) begin
          nxt_st.fsm = ST_IDLE; // R18
        end
      end
      ST_ADDR: begin
        nxt_st.page = 1'b0;
        if (susp) begin
          nxt_st.fsm = ST_HALT; // R17 R18
          nxt_st.ms_n = '1;
          nxt_st.sw_n = 1'b1;
        end else if (!st_ff.cond) begin
          // False condition: selects went out, no strobe
          nxt_st.fsm = ST_IDLE; // R9 R24
          nxt_st.done = 1'b1;
          nxt_st.ms_n = '1;
          nxt_st.sw_n = 1'b1;
        end else begin
          nxt_st.fsm = ST_STROBE;
          nxt_st.ctl_oe_n = 1'b0;
          nxt_st.data_oe_n = !st_ff.write;
          nxt_st.rd_n = st_ff.write; // R1
          nxt_st.wr_n = !st_ff.write; // R3
        end
      end
      ST_STROBE: begin
        if (susp) begin
          nxt_st.fsm = ST_HALT; // R17 R18
          nxt_st.rd_n = 1'b1;
          nxt_st.wr_n = 1'b1;
          nxt_st.sw_n = 1'b1;
          nxt_st.ms_n = '1;
        end else if (ack_eff) begin // R13 R25
          nxt_st.fsm = ST_IDLE;
          nxt_st.done = 1'b1;
          nxt_st.rdata = data_in;
          nxt_st.rd_n = 1'b1;
          nxt_st.wr_n = 1'b1;
          nxt_st.sw_n = 1'b1;
          nxt_st.ms_n = '1;
        end else begin
          nxt_st.ctl_oe_n = 1'b0;
          nxt_st.data_oe_n = st_ff.data_oe_n;
        end
      end
      ST_FLOAT: begin
        nxt_st.fsm = ST_GRANT; // R21
        nxt_st.grant_n = 1'b0;
      end
      ST_GRANT: begin
        if (!host_req) begin
          nxt_st.fsm = ST_IDLE; // R23
          nxt_st.grant_n = 1'b1;
        end
      end
      default: begin
        nxt_st.fsm = ST_IDLE;
      end
    endcase
    if (susp) begin
      nxt_st.ctl_oe_n = 1'b1; // R17
      nxt_st.data_oe_n = 1'b1; // R17
    end
    // Slave side: outside party strobes our memory
    slv_strobe = !(rd_n_in && wr_n_in);
    nxt_st.strobe_prev = !bus_master && slv_strobe;
    if (!bus_master && slv_strobe && !st_ff.strobe_prev) begin // R2 R4
      nxt_st.slv.req = 1'b1;
      nxt_st.slv.write = !sync_write_select_n_in; // R11 R12
      nxt_st.slv.addr = addr_in;
      nxt_st.slv.wdata = data_in;
    end
    nxt_st.ack_oe_n = !(!bus_master && slv_strobe); // R14
    nxt_st.ack_o = !slave_wait; // R14 R15
    if (!bus_master && !rd_n_in && !susp) begin
      nxt_st.data_oe_n = 1'b0;
      nxt_st.wdata = slave_rdata;
    end
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{fsm: ST_IDLE, ms_n: '1, rd_n: 1'b1, wr_n: 1'b1,
                 sw_n: 1'b1, ctl_oe_n: 1'b1, data_oe_n: 1'b1,
                 ack_o: 1'b1, ack_oe_n: 1'b1, grant_n: 1'b1,
                 ack_keep: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign core_done               = st_ff.done;
  assign core_rdata              = st_ff.rdata;
  assign host_bus_grant_n        = st_ff.grant_n;
  assign slave_req               = st_ff.slv;
  assign addr_out                = st_ff.addr;
  assign ctl_oe_n                = st_ff.ctl_oe_n;
  assign data_out                = st_ff.wdata;
  assign data_oe_n               = st_ff.data_oe_n;
  assign memory_bank_select_n    = st_ff.ms_n;
  assign page_out                = st_ff.page;
  assign rd_n_out                = st_ff.rd_n;
  assign wr_n_out                = st_ff.wr_n;
  assign sync_write_select_n_out = st_ff.sw_n;
  assign ack_out                 = st_ff.ack_o;
  assign ack_oe_n                = st_ff.ack_oe_n;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  sequence float_req_s;
    bus_master && !host_bus_request_n && st_ff.fsm == ST_IDLE;
  endsequence
  sequence float_then_grant_s;
    ##1 ctl_oe_n ##1 !host_bus_grant_n;
  endsequence

  host_handover_a: assert property (@(posedge clock) disable iff (!rst_n)
    float_req_s |-> float_then_grant_s) // R21
    else $error("bus not floated before grant");

  grant_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !host_bus_grant_n && !host_bus_request_n
      |=> !host_bus_grant_n) // R23
    else $error("grant dropped while host requests");

  suspend_float_a: assert property (@(posedge clock)
    disable iff (!rst_n)
    !suspend_bus_float_n |=> ctl_oe_n && data_oe_n) // R17
    else $error("bus driven after suspend sampled");

  halt_done_a: assert property (@(posedge clock) disable iff (!rst_n)
    st_ff.fsm == ST_HALT && !suspend_bus_float_n
      |=> !core_done) // R18
    else $error("access completed during suspend");

  ack_complete_a: assert property (@(posedge clock) disable iff (!rst_n)
    st_ff.fsm == ST_STROBE && ack_driven && !ack_in
      && suspend_bus_float_n |=> !core_done && !rd_n_out | !wr_n_out)
    // R25 R13
    else $error("access ended with acknowledge low");

  sw_with_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(st_ff.fsm == ST_ADDR) && st_ff.write
      |-> !sync_write_select_n_out && !ctl_oe_n) // R10
    else $error("write select not with address");

  strobe_master_a: assert property (@(posedge clock) disable iff (!rst_n)
    !bus_master && st_ff.fsm == ST_IDLE |=> rd_n_out && wr_n_out) // R5
    else $error("strobe driven while not master");

  page_bank_a: assert property (@(posedge clock) disable iff (!rst_n)
    page_out |-> memory_bank_select_n[0] == 1'b0) // R7
    else $error("page flagged outside bank 0");

  slave_dir_a: assert property (@(posedge clock) disable iff (!rst_n)
    slave_req.req |-> slave_req.write == !$past(sync_write_select_n_in))
    // R11
    else $error("slave direction not from write select");

  slave_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
    !bus_master && !rd_n_in && slave_wait |=> !ack_oe_n && !ack_out)
    // R14 R15
    else $error("slave did not hold acknowledge low");

endmodule

// ### ext_mem_model.sv
// Memory and peripheral model on the far side of the external bus
`timescale 1ns/10ps
module ext_mem_model
  import ext_bus_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Bus from the device, and the wait-state count from the bench
  input  wire logic [31:0] addr_out,
  input  wire logic [47:0] data_out,
  input  wire logic        ctl_oe_n,
  input  wire logic        rd_n_out,
  input  wire logic        wr_n_out,
  input  wire logic [1:0]  waits,
  // Answers to the device, and the write data seen for the bench
  output logic             ack_in,
  output logic             ack_driven,
  output logic [47:0]      data_in,
  output logic [47:0]      wdata_seen
);
  logic [1:0] cnt_ff;
  logic       last_ff;
  logic       strobe;
  logic [47:0] word;

  // ----------------------------------------
  // Wait states and read data
  // ----------------------------------------
  assign strobe     = !ctl_oe_n && (!rd_n_out || !wr_n_out);
  assign ack_driven = !ctl_oe_n;
  assign ack_in     = ack_driven ? !(strobe && cnt_ff < waits) : !last_ff;
  assign word       = {addr_out[15:0], ~addr_out};
  assign data_in    = (!ctl_oe_n && !rd_n_out) ? word : ~word;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff     <= 2'h0;
      last_ff    <= 1'b1;
      wdata_seen <= 48'h0;
    end else begin
      if (!strobe)
        cnt_ff <= 2'h0;
      else if (cnt_ff < waits)
        cnt_ff <= cnt_ff + 2'h1;
      if (ack_driven)
        last_ff <= ack_in;
      if (strobe && !wr_n_out && ack_in)
        wdata_seen <= data_out;
    end
  end
endmodule

// ### external_bus_strobe_protocol_bench.sv
// Testbench of the external bus strobe port
`timescale 1ns/10ps
module external_bus_strobe_protocol_bench import ext_bus_pkg::*;;
  logic        clock = 1'b0, rst_n = 1'b0, master = 1'b1, swait = 1'b0;
  logic        hreq_n = 1'b1, susp_n = 1'b1, row_ok = 1'b0;
  logic        rd_i = 1'b1, wr_i = 1'b1, sw_i = 1'b1, cnd, wr;
  logic        rd_o, wr_o, sw_o, rd_w, wr_w, sw_w, page, grant_n, done;
  logic        ctl_oe_n, data_oe_n, ack_m, ack_dm, ack_out, ack_oe_n;
  logic [1:0]  waits = 2'h0;
  logic [2:0]  psel = 3'h0;
  logic [3:0]  bsel = 4'h0, ms_n;
  logic [5:0]  mp_n = 6'h3F;
  logic [31:0] a, row, addr_i = 32'h0, addr_o;
  logic [47:0] data_i, data_o, d_ext, rdata, wseen;
  logic [47:0] sdata = 48'h0, srdata = 48'h0;
  core_req_t   req = '0;
  slave_req_t  sreq;
  int          fail_count = 0, n_tests = 0, i, n;

  // ----------------------------------------
  // Clock, wires and instances
  // ----------------------------------------
  always #2.5 clock = ~clock;
  assign data_i = master ? d_ext : sdata;
  assign rd_w   = ctl_oe_n ? rd_i : rd_o;
  assign wr_w   = ctl_oe_n ? wr_i : wr_o;
  assign sw_w   = ctl_oe_n ? sw_i : sw_o;

  ext_bus_port ext_bus_port_inst (
    .clock(clock), .rst_n(rst_n), .core_req(req),
    .page_size_sel(psel), .bank_size_sel(bsel), .core_done(done),
    .core_rdata(rdata), .bus_master(master), .mp_bus_request_n(mp_n),
    .host_bus_request_n(hreq_n), .host_bus_grant_n(grant_n),
    .suspend_bus_float_n(susp_n), .slave_req(sreq),
    .slave_wait(swait), .slave_rdata(srdata), .addr_in(addr_i),
    .addr_out(addr_o), .ctl_oe_n(ctl_oe_n), .data_in(data_i),
    .data_out(data_o), .data_oe_n(data_oe_n),
    .memory_bank_select_n(ms_n), .page_out(page), .rd_n_in(rd_w),
    .rd_n_out(rd_o), .wr_n_in(wr_w), .wr_n_out(wr_o),
    .sync_write_select_n_in(sw_w), .sync_write_select_n_out(sw_o),
    .ack_in(ack_oe_n ? ack_m : ack_out), .ack_driven(ack_dm | !ack_oe_n),
    .ack_out(ack_out), .ack_oe_n(ack_oe_n));

  ext_mem_model ext_mem_model_inst (
    .clock(clock), .rst_n(rst_n), .addr_out(addr_o), .data_out(data_o),
    .ctl_oe_n(ctl_oe_n), .rd_n_out(rd_o), .wr_n_out(wr_o),
    .waits(waits), .ack_in(ack_m), .ack_driven(ack_dm),
    .data_in(d_ext), .wdata_seen(wseen));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(string nm, logic [95:0] s, logic [95:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done;
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [3:0] ms_exp(logic [31:0] ad);
    return ~(4'h1 << ((ad >> (12 + bsel)) & 32'h3));
  endfunction

  task automatic wait_done;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    req.valid = 1'b0;
  endtask

  task automatic access(logic w_r, logic c, logic [31:0] ad, logic [1:0] w);
    logic pg, seen;
    logic [47:0] wd;
    wd = {16'($urandom), $urandom};
    waits = w;
    seen = 1'b0;
    n = 0;
    req = '{1'b1, w_r, c, ad, wd};
    pg = ms_exp(ad) == 4'hE && (!row_ok || row != ad >> (8 + psel));
    if (ms_exp(ad) == 4'hE) begin
      row = ad >> (8 + psel);
      row_ok = 1'b1;
    end
    while (done !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
      if (ctl_oe_n === 1'b0 && !seen) begin
        seen = 1'b1;
        chk("bank select", ms_n, ms_exp(ad));
        chk("page", page, pg);
        chk("write select", sw_o, !w_r);
      end
      if (ctl_oe_n === 1'b0 && !(rd_o && wr_o))
        chk("strobe", {c, rd_o, wr_o}, {1'b1, w_r, !w_r});
    end
    req.valid = 1'b0;
    chk("latency", n, c ? 3 + w : 2);
    if (c)
      chk("data", w_r ? wseen : rdata, w_r ? wd : {ad[15:0], ~ad});
    @(negedge clock);
    chk("idle select", ms_n, 4'hF);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(35));
    psel = 3'($urandom_range(0, 3));
    bsel = 4'($urandom_range(0, 3));
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    access(1'b0, 1'b1, 32'h0, 2'h0);
    access(1'b1, 1'b1, 32'h4, 2'h0);
    access(1'b0, 1'b1, 32'h1 << (8 + psel), 2'h3);
    access(1'b1, 1'b0, 32'h1 << (12 + bsel), 2'h2);
    for (i = 0; i < 30; i++) begin
      cnd = $urandom_range(0, 3) != 0;
      wr = 1'($urandom);
      a = $urandom_range(0, (1 << (14 + bsel)) - 1);
      if (!cnd)
        a = a & ~(32'h3 << (12 + bsel)) | 32'h1 << (12 + bsel);
      access(wr, cnd, a, 2'($urandom));
    end
    a = 32'h2 << (12 + bsel);
    waits = 2'h3;
    req = '{1'b1, 1'b0, 1'b1, a, 48'h0};
    repeat (3) @(negedge clock);
    susp_n = 1'b0;
    @(negedge clock);
    chk("suspend float", {ctl_oe_n, data_oe_n}, 2'h3);
    repeat (4) begin
      @(negedge clock);
      chk("halted", {done, ctl_oe_n}, 2'h1);
    end
    susp_n = 1'b1;
    wait_done();
    chk("resumed", {done, rdata}, {1'b1, a[15:0], ~a});
    @(negedge clock);
    mp_n = 6'($urandom_range(0, 62));
    hreq_n = 1'b0;
    @(negedge clock);
    chk("grant early", {grant_n, ctl_oe_n}, 2'h3);
    @(negedge clock);
    chk("grant", grant_n, 1'b0);
    req = '{1'b1, 1'b0, 1'b1, a, 48'h0};
    waits = 2'h0;
    repeat (5) begin
      @(negedge clock);
      chk("held", {grant_n, ctl_oe_n, done}, 3'h2);
    end
    hreq_n = 1'b1;
    @(negedge clock);
    chk("release", grant_n, 1'b1);
    wait_done();
    chk("after host", done, 1'b1);
    @(negedge clock);
    master = 1'b0;
    @(negedge clock);
    for (i = 0; i < 8; i++) begin
      wr = 1'($urandom);
      swait = 1'($urandom);
      addr_i = $urandom;
      sdata = {16'($urandom), $urandom};
      srdata = ~sdata;
      sw_i = !wr;
      rd_i = wr;
      wr_i = !wr;
      n = 0;
      while (sreq.req !== 1'b1 && n < 4) begin
        @(negedge clock);
        n++;
      end
      chk("slave req", {sreq.write, sreq.addr, wr ? sreq.wdata : 48'h0},
          {wr, addr_i, wr ? sdata : 48'h0});
      @(negedge clock);
      chk("slave ack", {ack_oe_n, ack_out, ctl_oe_n}, {2'(!swait), 1'b1});
      if (!wr)
        chk("slave data", {data_oe_n, data_o}, {1'b0, srdata});
      rd_i = 1'b1;
      wr_i = 1'b1;
      sw_i = 1'b1;
      repeat (2) @(negedge clock);
    end
    test_done();
  end

  initial begin
    #20000;
    fail_count++;
    test_done();
  end
endmodule
